// ---- common/cdpd_pkg.sv ----
package cdpd_pkg;

    // ------------------------------------------------------------
    // Command entry field positions (bit positions in 512-bit entry)
    // ------------------------------------------------------------
    localparam int ENTRY_W = 512;
    localparam int META_LSB = 128;
    localparam int FIRST_PAGE_LSB = 192;
    localparam int SECOND_PAGE_LSB = 256;
    localparam int WORD_TEN_LSB = 320;
    localparam int PTR_W = 64;
    localparam int WORD_W = 32;

    // ------------------------------------------------------------
    // Descriptor selector encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_PAGE = 2'h0;
    localparam logic [1:0] SEL_LIST_BYTE = 2'h1;
    localparam logic [1:0] SEL_LIST_QWORD = 2'h2;

    // Alignment masks for metadata pointer
    localparam logic [2:0] DWORD_MASK = 3'h3;
    localparam logic [2:0] QWORD_MASK = 3'h7;

    // ------------------------------------------------------------
    // Page size: 4KB base, offset top bit = 11 + page_shift
    // ------------------------------------------------------------
    localparam int BASE_PAGE_BITS = 12;
    localparam int SHIFT_W = 4;
    localparam int LEN_W = 32;
    localparam logic [LEN_W-1:0] ONE_LEN = 32'h0000_0001;

    typedef enum logic [1:0] {
        CDPD_SECOND_IGNORED,
        CDPD_SECOND_PAGE,
        CDPD_SECOND_LIST
    } cdpd_second_t;

    typedef struct packed {
        logic [PTR_W-1:0] metadata_pointer;
        logic [PTR_W-1:0] first_page_entry;
        logic [PTR_W-1:0] second_page_entry;
        logic [2*PTR_W-1:0] first_list_segment;
        logic [WORD_W-1:0] command_word_ten;
        logic page_mode;
        logic metadata_used;
        logic metadata_misaligned;
        logic bad_selector;
        cdpd_second_t second_use;
    } cdpd_result_t;

endpackage

// ---- design/cdpd_cross.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdpd_cross
    import cdpd_pkg::*;
(
    input wire logic [PTR_W-1:0] i_first_page_entry,
    input wire logic [LEN_W-1:0] i_length,
    input wire logic [SHIFT_W-1:0] i_page_shift,
    output cdpd_second_t o_second_use
);
    logic [LEN_W-1:0] page_bytes;
    logic [LEN_W-1:0] offset;
    logic [LEN_W:0] end_excl;
    logic [LEN_W:0] last_page;

    always_comb
    begin
        page_bytes = ONE_LEN << (BASE_PAGE_BITS + int'(i_page_shift));
        // Offset is low bits of entry below the page size
        offset = i_first_page_entry[LEN_W-1:0] & (page_bytes - ONE_LEN);
        end_excl = {1'b0, offset} + {1'b0, i_length};
        // Index of page holding the last byte, 0 = first page
        last_page = (end_excl - {{LEN_W{1'b0}}, 1'b1})
            >> (BASE_PAGE_BITS + int'(i_page_shift));
        if (i_length == '0 || last_page == '0)
            o_second_use = CDPD_SECOND_IGNORED;
        else if (last_page == {{LEN_W{1'b0}}, 1'b1})
            o_second_use = CDPD_SECOND_PAGE;
        else
            o_second_use = CDPD_SECOND_LIST;
    end
endmodule
`default_nettype wire

// ---- design/cdpd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdpd_decoder
    import cdpd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_entry_valid,
    input wire logic [ENTRY_W-1:0] i_entry,
    input wire logic [1:0] i_transfer_descriptor_select,
    input wire logic i_separate_metadata,
    input wire logic [LEN_W-1:0] i_transfer_length,
    input wire logic [SHIFT_W-1:0] i_page_shift,
    output logic o_result_valid,
    output cdpd_result_t o_result
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_b;
    logic rst_b;

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    logic [PTR_W-1:0] meta_ptr;
    logic [PTR_W-1:0] first_entry;
    logic [PTR_W-1:0] second_entry;
    logic [WORD_W-1:0] word_ten;
    cdpd_second_t second_use;
    cdpd_result_t next_result;

    assign meta_ptr = i_entry[META_LSB +: PTR_W];
    assign first_entry = i_entry[FIRST_PAGE_LSB +: PTR_W];
    assign second_entry = i_entry[SECOND_PAGE_LSB +: PTR_W];
    assign word_ten = i_entry[WORD_TEN_LSB +: WORD_W];

    cdpd_cross u_cross
    (
        .i_first_page_entry(first_entry),
        .i_length(i_transfer_length),
        .i_page_shift(i_page_shift),
        .o_second_use(second_use)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb
    begin
        next_result = '0;
        next_result.command_word_ten = word_ten;
        next_result.metadata_used = i_separate_metadata;
        // Pointer zeroed when unused so downstream never fetches stale metadata
        next_result.metadata_pointer = i_separate_metadata ? meta_ptr : '0;
        next_result.second_use = CDPD_SECOND_IGNORED;
        case (i_transfer_descriptor_select)
            SEL_PAGE:
            begin
                next_result.page_mode = 1'b1;
                next_result.first_page_entry = first_entry;
                next_result.second_use = second_use;
                // Reserved second entry must not leak into the transfer
                if (second_use != CDPD_SECOND_IGNORED)
                    next_result.second_page_entry = second_entry;
                next_result.metadata_misaligned = i_separate_metadata
                    && ((meta_ptr[2:0] & DWORD_MASK) != 3'h0);
            end
            SEL_LIST_BYTE:
            begin
                next_result.first_list_segment = {second_entry, first_entry};
                next_result.metadata_misaligned = 1'b0;
            end
            SEL_LIST_QWORD:
            begin
                next_result.first_list_segment = {second_entry, first_entry};
                next_result.metadata_misaligned = i_separate_metadata
                    && ((meta_ptr[2:0] & QWORD_MASK) != 3'h0);
            end
            default:
            begin
                // Reserved selector; command handling rejects it
                next_result.bad_selector = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            o_result_valid <= 1'b0;
        else
            o_result_valid <= i_entry_valid;
    end

    always_ff @(posedge i_sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            o_result <= '0;
        else if (i_entry_valid)
            o_result <= next_result;
    end

endmodule
`default_nettype wire

// ---- test/cdpd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdpd_host
    import cdpd_pkg::*;
(
    input wire logic [1:0] i_sel,
    input wire logic i_skew,
    input wire logic [PTR_W-1:0] i_meta,
    input wire logic [2*PTR_W-1:0] i_data_pointer,
    input wire logic [WORD_W-1:0] i_w10,
    output logic [ENTRY_W-1:0] o_entry
);
    always_comb
    begin
        o_entry = '0;
        o_entry[META_LSB+:PTR_W] = i_meta;
        o_entry[FIRST_PAGE_LSB+:2*PTR_W] = i_data_pointer;
        o_entry[WORD_TEN_LSB+:WORD_W] = i_w10;
        // Skew misplaces the buffer on purpose
        if (!i_skew && i_sel == SEL_PAGE)
            o_entry[META_LSB+:2] = 2'h0;
        if (!i_skew && i_sel == SEL_LIST_QWORD)
            o_entry[META_LSB+:3] = 3'h0;
    end
endmodule
`default_nettype wire

// ---- test/cdpd_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdpd_chk
    import cdpd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_entry_valid,
    input wire logic [ENTRY_W-1:0] i_entry,
    input wire logic [1:0] i_transfer_descriptor_select,
    input wire logic i_separate_metadata,
    input wire logic o_result_valid,
    input wire cdpd_result_t o_result
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic [1:0] s = i_transfer_descriptor_select;
    wire logic t = i_entry_valid && i_separate_metadata;
    chk_result_pulse: assert property (i_entry_valid |=> o_result_valid)
        else $error("no result");
    chk_idle_hold: assert property (!i_entry_valid |=> !o_result_valid && $stable(o_result))
        else $error("idle change");
    chk_word_ten: assert property (i_entry_valid |=> o_result.command_word_ten
        == $past(i_entry[WORD_TEN_LSB+:WORD_W])) else $error("word ten");
    chk_meta_gate: assert property (i_entry_valid && !i_separate_metadata |=>
        o_result.metadata_pointer == 0 && !o_result.metadata_misaligned) else $error("meta");
    chk_dword_meta: assert property (t && s == SEL_PAGE |=> o_result.metadata_misaligned
        == ($past(i_entry[META_LSB+:2]) != 0)) else $error("dword");
    chk_byte_meta: assert property (t && s == SEL_LIST_BYTE |=>
        !o_result.metadata_misaligned) else $error("byte");
    chk_qword_meta: assert property (t && s == SEL_LIST_QWORD |=> o_result.metadata_misaligned
        == ($past(i_entry[META_LSB+:3]) != 0)) else $error("qword");
    chk_list_seg: assert property (i_entry_valid && s inside {1, 2} |=>
        o_result.first_list_segment == $past(i_entry[FIRST_PAGE_LSB+:128])) else $error("list");
endmodule
bind cdpd_decoder cdpd_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_entry_valid(i_entry_valid), .i_entry(i_entry), .i_separate_metadata(i_separate_metadata),
    .i_transfer_descriptor_select(i_transfer_descriptor_select),
    .o_result_valid(o_result_valid), .o_result(o_result));
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cdpd_pkg::*;
    logic clk = 0, rst_b = 0, vld = 0, sep = 0, skew = 0;
    logic [1:0] sel = 0;
    logic [LEN_W-1:0] len = 0;
    logic [SHIFT_W-1:0] sh = 0;
    logic [PTR_W-1:0] meta = 0;
    logic [127:0] data_pointer = 0;
    logic [WORD_W-1:0] w10 = 0;
    logic [ENTRY_W-1:0] entry;
    logic rv;
    cdpd_result_t r;
    int errors = 0, compares = 0;
    always #25 clk = ~clk;
    cdpd_host host (.i_sel(sel), .i_skew(skew), .i_meta(meta), .i_data_pointer(data_pointer), .i_w10(w10),
        .o_entry(entry));
    cdpd_decoder dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_entry_valid(vld), .i_entry(entry),
        .i_transfer_descriptor_select(sel), .i_separate_metadata(sep), .i_transfer_length(len),
        .i_page_shift(sh), .o_result_valid(rv), .o_result(r));
    task check(input logic [127:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Flags f: separate metadata, skewed buffer, misalignment expected
    task send(input logic [1:0] s, input logic [2:0] f, input logic [15:0] l, a, b,
        input logic [3:0] p, u);
        logic e;
        @(negedge clk);
        {sep, skew, e} = f;
        sel = s;
        len = {16'h0, l};
        sh = p;
        meta = {48'h0, a};
        data_pointer = {48'h9, b, 48'h0, b};
        w10 = {a, b};
        vld = 1;
        @(posedge clk);
        #1;
        check(rv, 1);
        check(r.command_word_ten, w10);
        check(r.metadata_misaligned, e);
        check(r.metadata_pointer, sep ? entry[META_LSB+:PTR_W] : 0);
        check(r.bad_selector, s == 2'h3);
        check(r.metadata_used, sep);
        check(r.page_mode, s == SEL_PAGE);
        if (s == SEL_PAGE)
        begin
            check(r.second_use, u);
            check(r.second_page_entry, u == 0 ? 0 : data_pointer[127:64]);
            check(r.first_page_entry, data_pointer[63:0]);
        end
        else if (s != 2'h3)
            check(r.first_list_segment, data_pointer);
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        rst_b = 1;
        repeat (3) @(negedge clk);
        // Back to back entries, no idle cycle between them
        send(2'h0, 3'h4, 16'h1000, 16'h1004, 16'h2000, 4'h0, 2'h0);
        send(2'h0, 3'h4, 16'h1000, 16'h1004, 16'h2008, 4'h0, 2'h1);
        send(2'h0, 3'h0, 16'h2000, 16'h1004, 16'h2000, 4'h0, 2'h1);
        send(2'h0, 3'h4, 16'h2001, 16'h1004, 16'h2000, 4'h0, 2'h2);
        send(2'h0, 3'h4, 16'h2000, 16'h1004, 16'h2008, 4'h0, 2'h2);
        send(2'h0, 3'h4, 16'h2000, 16'h1004, 16'h2000, 4'h1, 2'h0);
        send(2'h0, 3'h4, 16'h0064, 16'h1004, 16'h2FFC, 4'h0, 2'h1);
        send(2'h0, 3'h7, 16'h0010, 16'h1006, 16'h2000, 4'h0, 2'h0);
        send(2'h1, 3'h6, 16'h0010, 16'h1003, 16'h2000, 4'h0, 2'h0);
        send(2'h2, 3'h7, 16'h0010, 16'h1004, 16'h2000, 4'h0, 2'h0);
        send(2'h2, 3'h4, 16'h0010, 16'h1004, 16'h2000, 4'h0, 2'h0);
        send(2'h3, 3'h0, 16'h0010, 16'h1004, 16'h2000, 4'h0, 2'h0);
        send(2'h0, 3'h2, 16'h0010, 16'h1006, 16'h2000, 4'h0, 2'h0);
        @(negedge clk);
        vld = 0;
        repeat (3) @(negedge clk);
        check(rv, 0);
        results;
    end
    initial
    begin
        repeat (1000) @(posedge clk);
        errors++;
        results;
    end
endmodule
`default_nettype wire
